// file: verilog/seb_defs.svh
// constants shared by both ends of the two-wire memory link
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH
`define SEB_TYPE_CODE     4'ha
`define SEB_ADDR_W        11
`define SEB_PAGE_BITS     4
`define SEB_MEM_DEPTH     2048
`define SEB_WRITE_TIME_US 10000
`define SEB_CLK_MHZ       10
`define SEB_WRITE_CYCLES  (`SEB_WRITE_TIME_US * `SEB_CLK_MHZ)
`define SEB_SCL_HALF      4
`endif

// file: verilog/seb_pkg.sv
// types shared by both ends of the two-wire memory link
package seb_pkg;
   typedef enum logic [2:0] {
      SEB_DEV_IDLE,
      SEB_DEV_ADDR,
      SEB_DEV_WORD,
      SEB_DEV_WDATA,
      SEB_DEV_RDATA,
      SEB_DEV_MACK
   } seb_dev_state_t;
   typedef enum logic [3:0] {
      SEB_HST_IDLE,
      SEB_HST_START,
      SEB_HST_BIT_LO,
      SEB_HST_BIT_HI,
      SEB_HST_STOP_LO,
      SEB_HST_STOP_HI,
      SEB_HST_DONE
   } seb_hst_state_t;
endpackage

// file: verilog/seb_link_if.sv
// two-wire link between the bus master and the memory device
`timescale 1ns/1ps
`default_nettype none
interface seb_link_if;
   logic scl;
   logic sda_host_out;
   logic sda_host_oe;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic sda;
   // open-drain wired-and with pull-up
   assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
   modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
   modport host (output scl, input sda, output sda_host_out, output sda_host_oe);
endinterface
`default_nettype wire

// file: verilog/seb_device.sv
// memory device end: two-wire slave, address counter and write sequencer
`timescale 1ns/1ps
`default_nettype none
`include "seb_defs.svh"
// Functional notes
// [RULE1] sda fall with scl high starts
// [RULE2] stop during read returns to standby
// [RULE3] stop during write launches programming
// [RULE4] sda changes only while scl low
// [RULE5] eight-bit bytes, ninth clock acknowledges
// [RULE6] programming cycle ignores bus, no acknowledge
// [RULE7] answer only matching four-bit type code
// [RULE8] three block bits pick 256-byte block
// [RULE9] byte write: address, word, data, stop
// [RULE10] page write up to sixteen bytes
// [RULE11] write advances low four bits, wraps
// [RULE12] program exactly received bytes from start; code copies all 16 page slots
// [RULE13] protect input high suppresses every write
// [RULE14] master holds protect until programming ends
// [RULE15] poll by address; acknowledge means finished
// [RULE16] master polls with read direction
// [RULE17] current read ignores block bits
// [RULE18] read counter advances on eighth fall
// [RULE19] master ack continues, nack stop ends
// [RULE20] sequential read wraps to zero
// [RULE21] random read: dummy write then read
// [RULE22] write low bits advance on eighth fall
// [RULE23] any start resets interface state
// [RULE24] mismatched address leaves bus released
module seb_device #(
   parameter int WRITE_CYCLES = `SEB_WRITE_CYCLES
) (
   input  wire logic   core_clk,
   input  wire logic   rst_n,
   seb_link_if.dev     link,
   input  wire logic   write_protect,
   output logic        busy,
   output logic [10:0] addr_ptr
);
   // *********************************************
   // pin synchronisers and edge detection
   // *********************************************
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       scl_q;
   logic       sda_q;
   logic       wp_m_q;
   logic       wp_q;
   // two flops before any logic looks at the pins
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q      <= 1'b1;
         sda_q      <= 1'b1;
         wp_m_q     <= 1'b0;
         wp_q       <= 1'b0;
      end else begin
         scl_sync_q <= {scl_sync_q[0], link.scl};
         sda_sync_q <= {sda_sync_q[0], link.sda};
         scl_q      <= scl_sync_q[1];
         sda_q      <= sda_sync_q[1];
         wp_m_q     <= write_protect;
         wp_q       <= wp_m_q;
      end
   end
   wire scl_s    = scl_sync_q[1];
   wire sda_s    = sda_sync_q[1];
   wire scl_rise = scl_s && !scl_q;
   wire scl_fall = !scl_s && scl_q;
   // sda moving while scl stays high is framing, never data
   wire start_ev = scl_s && scl_q && sda_q && !sda_s;  // see [RULE1] see [RULE4]
   wire stop_ev  = scl_s && scl_q && !sda_q && sda_s;  // see [RULE4]

   // *********************************************
   // memory, counters and state
   // *********************************************
   logic [7:0]  mem_q [0:`SEB_MEM_DEPTH-1];
   logic [7:0]  page_q [0:(1<<`SEB_PAGE_BITS)-1];
   seb_pkg::seb_dev_state_t st_q;
   logic [3:0]  bit_q;
   logic [7:0]  shift_q;
   logic        ack_phase_q;
   logic        ack_drive_q;
   logic        out_bit_q;
   logic        out_en_q;
   logic [10:0] ptr_q;
   logic [10:0] wstart_q;
   logic [4:0]  wcount_q;
   logic [3:0]  wfirst_q;
   logic        wr_seq_q;
   logic        prog_q;
   logic [$clog2(WRITE_CYCLES+1)-1:0] prog_cnt_q;
   logic [4:0]  prog_idx_q;

   // bits are counted on rises, so the fall right after a start is not a bit
   wire        byte_done = scl_fall && (bit_q == 4'h8) && !ack_phase_q;
   wire [7:0]  rx_byte   = shift_q;
   wire        type_ok   = rx_byte[7:4] == `SEB_TYPE_CODE;      // see [RULE7]
   wire [10:0] ptr_inc   = ptr_q + 11'h001;                      // see [RULE20]
   wire [10:0] ptr_page  = {ptr_q[10:4], ptr_q[3:0] + 4'h1};     // see [RULE11]
   wire [3:0]  prog_off  = wfirst_q + prog_idx_q[3:0];
   wire [10:0] prog_addr = {wstart_q[10:4], prog_off};

   assign busy     = prog_q;
   assign addr_ptr = ptr_q;
   assign link.sda_dev_out = 1'b0;
   // open drain: only ever pulls low
   assign link.sda_dev_oe  = (ack_drive_q || (out_en_q && !out_bit_q)) && !prog_q; // see [RULE6] see [RULE24]

   // *********************************************
   // bus sequencer
   // *********************************************
   // bits shift in on scl rise, outputs change on scl fall
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q        <= seb_pkg::SEB_DEV_IDLE;
         bit_q       <= 4'h0;
         shift_q     <= 8'h00;
         ack_phase_q <= 1'b0;
         ack_drive_q <= 1'b0;
         out_bit_q   <= 1'b1;
         out_en_q    <= 1'b0;
         ptr_q       <= 11'h000;
         wstart_q    <= 11'h000;
         wcount_q    <= 5'h00;
         wfirst_q    <= 4'h0;
         wr_seq_q    <= 1'b0;
      end else if (prog_q) begin
         // programming: all traffic ignored
         st_q        <= seb_pkg::SEB_DEV_IDLE;                   // see [RULE6] see [RULE15]
         ack_drive_q <= 1'b0;
         out_en_q    <= 1'b0;
         wr_seq_q    <= 1'b0;
         wcount_q    <= 5'h00;
      end else if (start_ev) begin
         st_q        <= seb_pkg::SEB_DEV_ADDR;                   // see [RULE23]
         bit_q       <= 4'h0;
         ack_phase_q <= 1'b0;
         ack_drive_q <= 1'b0;
         out_en_q    <= 1'b0;
         wr_seq_q    <= 1'b0;
         wcount_q    <= 5'h00;
      end else if (stop_ev) begin
         // a stop ends a read quietly; a write goes to programming
         st_q        <= seb_pkg::SEB_DEV_IDLE;                   // see [RULE2] see [RULE3]
         ack_drive_q <= 1'b0;
         out_en_q    <= 1'b0;
         wr_seq_q    <= 1'b0;
      end else if (st_q != seb_pkg::SEB_DEV_IDLE) begin
         if (scl_rise && !ack_phase_q) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 4'h1;
         end
         // master answer to a read byte sampled on ninth rise
         if (scl_rise && ack_phase_q && st_q == seb_pkg::SEB_DEV_MACK) begin
            st_q <= sda_s ? seb_pkg::SEB_DEV_IDLE : seb_pkg::SEB_DEV_RDATA; // see [RULE19]
         end
         if (scl_fall && ack_phase_q) begin
            // end of ninth clock
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            bit_q       <= 4'h0;
            out_en_q    <= (st_q == seb_pkg::SEB_DEV_RDATA);
            out_bit_q   <= mem_q[ptr_q][7];
            shift_q     <= mem_q[ptr_q];
         end else if (scl_fall && !byte_done) begin
            // next bit to send sits at the top after each shift
            out_bit_q <= shift_q[7];
         end else if (byte_done) begin
            bit_q       <= 4'h0;
            ack_phase_q <= 1'b1;                                  // see [RULE5]
            case (st_q)
               seb_pkg::SEB_DEV_ADDR: begin
                  if (!type_ok) begin
                     st_q <= seb_pkg::SEB_DEV_IDLE;               // see [RULE24]
                  end else if (rx_byte[0]) begin
                     ack_drive_q <= 1'b1;
                     st_q        <= seb_pkg::SEB_DEV_RDATA;       // see [RULE17]
                  end else begin
                     ack_drive_q <= 1'b1;
                     wstart_q    <= {rx_byte[3:1], 8'h00};        // see [RULE8]
                     st_q        <= seb_pkg::SEB_DEV_WORD;
                  end
               end
               seb_pkg::SEB_DEV_WORD: begin
                  ack_drive_q <= 1'b1;
                  ptr_q       <= {wstart_q[10:8], rx_byte};       // see [RULE21] see [RULE8]
                  wstart_q    <= {wstart_q[10:8], rx_byte};
                  wfirst_q    <= rx_byte[3:0];
                  st_q        <= seb_pkg::SEB_DEV_WDATA;
               end
               seb_pkg::SEB_DEV_WDATA: begin
                  ack_drive_q <= 1'b1;                            // see [RULE9] see [RULE10]
                  ptr_q       <= ptr_page;                        // see [RULE22] see [RULE11]
                  wr_seq_q    <= 1'b1;
                  if (wcount_q != 5'h10) begin
                     wcount_q <= wcount_q + 5'h01;
                  end
               end
               seb_pkg::SEB_DEV_RDATA: begin
                  out_en_q <= 1'b0;
                  ptr_q    <= ptr_inc;                            // see [RULE18] see [RULE20]
                  st_q     <= seb_pkg::SEB_DEV_MACK;
               end
               default: st_q <= seb_pkg::SEB_DEV_IDLE;
            endcase
         end
      end
   end

   // page buffer: bytes land at their in-page slot, so excess bytes overwrite
   always_ff @(posedge core_clk) begin
      if (!prog_q && byte_done && st_q == seb_pkg::SEB_DEV_WDATA) begin
         page_q[ptr_q[3:0]] <= rx_byte;                          // see [RULE11]
      end
   end

   // *********************************************
   // programming cycle
   // *********************************************
   // stop after data holds busy for the write time, copying all 16 page-buffer slots in its first cycles
   wire prog_go = stop_ev && wr_seq_q && !prog_q;                 // see [RULE3]
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prog_q     <= 1'b0;
         prog_cnt_q <= '0;
         prog_idx_q <= 5'h00;
      end else if (prog_go) begin
         prog_q     <= 1'b1;
         prog_cnt_q <= '0;
         prog_idx_q <= 5'h00;
      end else if (prog_q) begin
         if (prog_idx_q != wcount_q) begin
            prog_idx_q <= prog_idx_q + 5'h01;
         end
         prog_cnt_q <= prog_cnt_q + 1'b1;
         if (prog_cnt_q == ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES - 1)) begin
            prog_q <= 1'b0;
         end
      end
   end

   // copy every page slot, as the received count clears once busy; protect blocks every write
   always_ff @(posedge core_clk) begin
      if (prog_q && prog_idx_q != wcount_q && !wp_q) begin       // see [RULE12] see [RULE13] see [RULE14]
         mem_q[prog_addr] <= page_q[prog_off];
      end
   end
endmodule // seb_device
`default_nettype wire

// file: verilog/seb_host.sv
// bus master end: generates scl, frames bytes and reports acknowledges
`timescale 1ns/1ps
`default_nettype none
`include "seb_defs.svh"
module seb_host #(
   parameter int HALF = `SEB_SCL_HALF
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   seb_link_if.host        link,
   input  wire logic       req_valid,
   output logic            req_ready,
   input  wire logic       req_start,
   input  wire logic       req_stop,
   input  wire logic       req_read,
   input  wire logic       req_ack,
   input  wire logic [7:0] req_data,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_ack
);
   // *********************************************
   // master sequencer: optional start, 9 bits, optional stop
   // *********************************************
   seb_pkg::seb_hst_state_t st_q;
   logic [1:0] sda_sync_q;
   logic [7:0] cnt_q;
   logic [3:0] bit_q;
   logic [8:0] tx_q;
   logic [8:0] rx_q;
   logic       stop_q;
   logic       scl_q;
   logic       sda_q;
   logic       rsp_valid_q;
   wire        tick = cnt_q == 8'(HALF - 1);
   wire        sda_s = sda_sync_q[1];
   assign req_ready        = st_q == seb_pkg::SEB_HST_IDLE;
   assign link.scl         = scl_q;
   assign link.sda_host_out = 1'b0;
   assign link.sda_host_oe  = !sda_q;
   assign rsp_valid        = rsp_valid_q;
   assign rsp_data         = rx_q[8:1];
   assign rsp_ack          = !rx_q[0];
   // data bits move only while scl is low; start and stop while high
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q <= seb_pkg::SEB_HST_IDLE; sda_sync_q <= 2'h3; cnt_q <= 8'h00; bit_q <= 4'h0;
         tx_q <= 9'h1ff; rx_q <= 9'h000; stop_q <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1;
         rsp_valid_q <= 1'b0;
      end else begin
         sda_sync_q  <= {sda_sync_q[0], link.sda};
         rsp_valid_q <= 1'b0;
         cnt_q       <= tick ? 8'h00 : cnt_q + 8'h01;
         case (st_q)
            seb_pkg::SEB_HST_IDLE: begin
               cnt_q <= 8'h00;
               if (req_valid) begin
                  // reading: release data bits, drive ack/nack in ninth
                  tx_q   <= req_read ? {8'hff, !req_ack} : {req_data, 1'b1};
                  stop_q <= req_stop;
                  bit_q  <= 4'h0;
                  st_q   <= req_start ? seb_pkg::SEB_HST_START : seb_pkg::SEB_HST_BIT_LO;
                  // release sda first; scl rises a phase later
                  if (req_start) begin
                     sda_q <= 1'b1;
                  end
               end
            end
            seb_pkg::SEB_HST_START: if (tick) begin
               if (!scl_q) begin
                  scl_q <= 1'b1;
               end else begin
                  sda_q <= 1'b0;
                  st_q  <= seb_pkg::SEB_HST_BIT_LO;
               end
            end
            seb_pkg::SEB_HST_BIT_LO: if (tick) begin
               if (!scl_q) begin
                  scl_q <= 1'b1;
                  st_q  <= seb_pkg::SEB_HST_BIT_HI;
               end else begin
                  scl_q <= 1'b0;
               end
            end
            seb_pkg::SEB_HST_BIT_HI: if (tick) begin
               rx_q  <= {rx_q[7:0], sda_s};
               scl_q <= 1'b0;
               bit_q <= bit_q + 4'h1;
               st_q  <= (bit_q == 4'h8) ? (stop_q ? seb_pkg::SEB_HST_STOP_LO : seb_pkg::SEB_HST_DONE)
                                        : seb_pkg::SEB_HST_BIT_LO;
            end
            seb_pkg::SEB_HST_STOP_LO: if (tick) begin
               scl_q <= 1'b1;
               st_q  <= seb_pkg::SEB_HST_STOP_HI;
            end
            seb_pkg::SEB_HST_STOP_HI: if (tick) begin
               sda_q <= 1'b1;
               st_q  <= seb_pkg::SEB_HST_DONE;
            end
            seb_pkg::SEB_HST_DONE: begin
               rsp_valid_q <= 1'b1;
               st_q        <= seb_pkg::SEB_HST_IDLE;
            end
            default: st_q <= seb_pkg::SEB_HST_IDLE;
         endcase
         // sda moves two cycles after scl falls, never with an scl edge (HALF >= 3)
         if (!scl_q && cnt_q == 8'h01 &&
             (st_q == seb_pkg::SEB_HST_BIT_LO || st_q == seb_pkg::SEB_HST_STOP_LO)) begin
            sda_q <= (st_q == seb_pkg::SEB_HST_STOP_LO) ? 1'b0 : tx_q[8 - bit_q];
         end
      end
   end
endmodule // seb_host
`default_nettype wire

// file: verif/seb_link_sva.sv
// checker watching the two-wire link between the bus master and the memory device
`timescale 1ns/1ps
`default_nettype none
`include "seb_defs.svh"
module seb_link_sva (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_host_out,
   input wire logic sda_host_oe,
   input wire logic sda_dev_out,
   input wire logic sda_dev_oe,
   input wire logic sda
);
   // ***********************************
   // framing tracker
   // ***********************************
   logic       scl_q;
   logic       sda_q;
   logic       live_q;
   logic [4:0] nbits_q;
   logic [3:0] kind_q;
   // start and stop seen only while scl stayed high
   wire logic       start_w = scl && scl_q && sda_q && !sda;
   wire logic       stop_w  = scl && scl_q && !sda_q && sda;
   wire logic       rise_w  = scl && !scl_q;
   wire logic       live_d  = start_w || (live_q && !stop_w);
   // count saturates at 30 so 31 can mean outside any frame
   wire logic [4:0] nbits_d = start_w ? 5'h00 : stop_w ? 5'h1f :
                              (rise_w && nbits_q < 5'h1e) ? nbits_q + 5'h01 : nbits_q;
   // previous wire levels
   always_ff @(posedge core_clk) begin
      scl_q <= scl;
      sda_q <= sda;
   end
   // bit count and type code of the current frame
   always_ff @(posedge core_clk) begin
      live_q  <= rst_n && live_d;
      nbits_q <= rst_n ? nbits_d : 5'h1f;
      kind_q  <= (rise_w && nbits_q < 5'h04) ? {kind_q[2:0], sda} : kind_q;
   end
   // ***********************************
   // assertions
   // ***********************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_dev_held_high: assert property (
      scl && $past(scl) |-> $stable(sda_dev_oe)) else $error("device moved sda while scl high");
   chk_sda_scl_apart: assert property (
      $changed(sda) |-> $stable(scl)) else $error("sda and scl changed together");
   chk_dev_open_drain: assert property (
      sda_dev_oe |-> !sda_dev_out) else $error("device drove sda high");
   chk_host_open_drain: assert property (
      sda_host_oe |-> !sda_host_out) else $error("master drove sda high");
   chk_dev_ack_window: assert property (
      $rose(sda_dev_oe) |-> !scl && nbits_q >= 5'h08) else $error("device drove sda too early");
   chk_addr_silent: assert property (
      live_q && nbits_q < 5'h08 |-> !sda_dev_oe) else $error("device drove during address bits");
   chk_foreign_silent: assert property (
      live_q && nbits_q >= 5'h04 && kind_q != `SEB_TYPE_CODE |-> !sda_dev_oe)
      else $error("device answered a foreign type code");
   chk_stop_silent: assert property (
      !live_q |-> !sda_dev_oe) else $error("device drove sda outside a frame");
   chk_host_ack_free: assert property (
      rise_w && nbits_q == 5'h08 |-> !sda_host_oe) else $error("master held sda in ack slot");
endmodule // seb_link_sva
`default_nettype wire

// file: verif/test_serial_eeprom_bus_slave.sv
// self-checking bench: master and memory ends joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "seb_defs.svh"
module test_serial_eeprom_bus_slave;
   // ***********************************
   // stimulus, ends and checker
   // ***********************************
   logic        core_clk = 1'b0, rst_n = 1'b0, write_protect = 1'b0, req_valid = 1'b0;
   logic        req_start = 1'b0, req_stop = 1'b0, req_read = 1'b0, req_ack = 1'b0;
   logic        req_ready, rsp_valid, rsp_ack, busy, a;
   logic [7:0]  req_data = 8'h00, rsp_data, q;
   logic [10:0] addr_ptr;
   int          miscompares = 0, n_compared = 0;
   seb_link_if link ();
   seb_host i_seb_host (.core_clk, .rst_n, .link(link), .req_valid, .req_ready, .req_start, .req_stop,
                        .req_read, .req_ack, .req_data, .rsp_valid, .rsp_data, .rsp_ack);
   // short programming time keeps polling loops brief
   seb_device #(.WRITE_CYCLES(400)) i_seb_device (.core_clk, .rst_n, .link(link), .write_protect,
                                                  .busy, .addr_ptr);
   seb_link_sva i_seb_link_sva (.core_clk, .rst_n, .scl(link.scl), .sda_host_out(link.sda_host_out),
                                .sda_host_oe(link.sda_host_oe), .sda_dev_out(link.sda_dev_out),
                                .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));
   // 10 MHz core clock
   always #50 core_clk = ~core_clk;
   // ***********************************
   // shared tasks
   // ***********************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one byte through the master; bounded waits on ready and response
   task automatic xfer(input logic st, sp, rd, ak, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk) #1;
      {req_start, req_stop, req_read, req_ack, req_data} = {st, sp, rd, ak, d};
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 9000) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk) #1 req_valid = 1'b0;
      do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 9000);
      if (n >= 9000) begin
         miscompares++;
         print_verdict;
      end
      q = rsp_data;
      a = rsp_ack;
   endtask
   task automatic dev(input logic [2:0] b, input logic rd, input logic sp);
      xfer(1'b1, sp, 1'b0, 1'b0, {`SEB_TYPE_CODE, b, rd});
   endtask
   task automatic seek(input logic [10:0] ad);
      dev(ad[10:8], 1'b0, 1'b0);
      chk(16'(a), 16'h1);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, ad[7:0]);
      chk(16'(a), 16'h1);
      chk(16'(addr_ptr), 16'(ad));
   endtask
   task automatic rdb(input logic last, input logic [7:0] e);
      xfer(1'b0, last, 1'b1, !last, 8'hff);
      chk(16'(q), 16'(e));
   endtask
   // poll with read direction; busy device must stay silent
   task automatic poll_done;
      int k;
      dev(3'h0, 1'b1, 1'b0);
      chk(16'({a, busy}), 16'h1);
      for (k = 0; k < 40 && a !== 1'b1; k++) dev(3'h0, 1'b1, 1'b0);
      chk(16'({a, busy}), 16'h2);
      xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'hff);
   endtask
   task automatic wr(input logic [10:0] ad, input int n, input logic [7:0] d0);
      int i;
      seek(ad);
      for (i = 0; i < n; i++) begin
         xfer(1'b0, i == n - 1, 1'b0, 1'b0, d0 + 8'(i));
         chk(16'(a), 16'h1);
      end
      chk(16'(addr_ptr), 16'({ad[10:4], ad[3:0] + 4'(n)}));
      poll_done;
   endtask
   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_byte;
      wr(11'h345, 1, 8'h5a);
      seek(11'h345);
      dev(3'h3, 1'b1, 1'b0);
      rdb(1'b1, 8'h5a);
      chk(16'(addr_ptr), 16'h0346);
   endtask
   // 18 bytes from offset 14: the last two land on offsets 14 and 15 again
   task automatic t_page;
      int i;
      wr(11'h12e, 18, 8'h10);
      seek(11'h120);
      dev(3'h1, 1'b1, 1'b0);
      for (i = 0; i < 16; i++) rdb(i == 15, 8'h10 + 8'((i + 2) % 16 + ((i + 2) % 16 < 2 ? 16 : 0)));
   endtask
   task automatic t_protect;
      @(posedge core_clk) #1 write_protect = 1'b1;
      wr(11'h345, 1, 8'ha5);
      @(posedge core_clk) #1 write_protect = 1'b0;
      seek(11'h345);
      dev(3'h3, 1'b1, 1'b0);
      rdb(1'b1, 8'h5a);
   endtask
   task automatic t_wrap;
      wr(11'h7ff, 1, 8'h3c);
      wr(11'h000, 1, 8'hc3);
      seek(11'h7ff);
      dev(3'h7, 1'b1, 1'b0);
      rdb(1'b1, 8'h3c);
      chk(16'({busy, addr_ptr}), 16'h0000);
      dev(3'h5, 1'b1, 1'b0);
      rdb(1'b1, 8'hc3);
      seek(11'h7ff);
      dev(3'h2, 1'b1, 1'b0);
      rdb(1'b0, 8'h3c);
      rdb(1'b1, 8'hc3);
   endtask
   // foreign type code after a dummy write: no answer, pointer kept
   task automatic t_foreign;
      seek(11'h345);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h57);
      chk(16'(a), 16'h0);
      xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'hff);
      chk(16'(q), 16'h00ff);
      dev(3'h6, 1'b1, 1'b0);
      chk(16'(a), 16'h1);
      rdb(1'b1, 8'h5a);
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (16) @(posedge core_clk);
      #1 rst_n = 1'b1;
      t_byte;
      t_page;
      t_protect;
      t_wrap;
      t_foreign;
      print_verdict;
   end
endmodule // test_serial_eeprom_bus_slave
`default_nettype wire
